// ===== hdl/idt_pkg.sv
// constants, types and register map of the interval down timer
//
// Contract
// R01 - count decrements once per counting clock
// R02 - six 16-bit registers, status then control
// R03 - zero count sets sticky timeout_flag
// R04 - writing 0 clears timeout_flag
// R05 - counting_flag shows whether timer runs
// R06 - status writes never change counting_flag
// R07 - zero count reloads programmed start value
// R08 - continuous_mode 1 keeps counting after reload
// R09 - continuous_mode 0 stops, clears counting_flag
// R10 - start bit runs, halt bit suspends
// R11 - two period halves hold start count
// R12 - reset start count is 6.25 million
// R13 - snapshot write captures live 32-bit count
// R14 - control holds timeout_irq_enable bit
// R15 - enabled timeout raises interrupt request
// R16 - any status write drops pending interrupt
// R17 - timeout_flag sits at status bit 0
// R18 - software writes low half, then high; the bench writes the high half first
// R19 - fixed bit positions; start, halt read zero
// R20 - reset leaves timer stopped and quiet
// R21 - halt beats start; start resumes count
package idt_pkg;

  localparam logic [31:0] IDT_ADDR_STATUS = 32'h1000_2000;
  localparam logic [31:0] IDT_ADDR_CONTROL = 32'h1000_2004;
  localparam logic [31:0] IDT_ADDR_PERIOD_LO = 32'h1000_2008;
  localparam logic [31:0] IDT_ADDR_PERIOD_HI = 32'h1000_200C;
  localparam logic [31:0] IDT_ADDR_SNAP_LO = 32'h1000_2010;
  localparam logic [31:0] IDT_ADDR_SNAP_HI = 32'h1000_2014;

  localparam int IDT_STAT_TO_BIT = 0;
  localparam int IDT_STAT_RUN_BIT = 1;
  localparam int IDT_CTRL_ITO_BIT = 0;
  localparam int IDT_CTRL_CONTINUOUS_MODE_BIT = 1;
  localparam int IDT_CTRL_START_BIT = 2;
  localparam int IDT_CTRL_HALT_BIT = 3;

  localparam int IDT_TICK_HZ = 50_000_000;
  localparam int IDT_DEFAULT_PERIOD_MS = 125;
  localparam logic [31:0] IDT_DEFAULT_PERIOD =
    32'(IDT_TICK_HZ / 1000 * IDT_DEFAULT_PERIOD_MS);

  localparam logic [31:0] IDT_COUNT_ZERO = 32'h0000_0000;
  localparam logic [31:0] IDT_COUNT_ONE = 32'h0000_0001;
  localparam logic [15:0] IDT_HALF_ZERO = 16'h0000;

  typedef enum logic [2:0] {
    IDT_SEL_STATUS = 3'b000,
    IDT_SEL_CONTROL = 3'b001,
    IDT_SEL_PERIOD_LO = 3'b010,
    IDT_SEL_PERIOD_HI = 3'b011,
    IDT_SEL_SNAP_LO = 3'b100,
    IDT_SEL_SNAP_HI = 3'b101,
    IDT_SEL_NONE = 3'b111
  } idt_sel_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [31:0] addr;
    logic [15:0] wdata;
  } idt_req_t;

  typedef struct packed {
    logic timeout_flag;
    logic counting_flag;
    logic irq_pend;
    logic timeout_irq_enable;
    logic continuous_mode;
    logic [15:0] period_lo;
    logic [15:0] period_hi;
    logic [15:0] snap_lo;
    logic [15:0] snap_hi;
    logic [15:0] rdata;
    logic rvalid;
  } idt_state_t;

  typedef struct packed {
    logic [31:0] count;
  } idt_cnt_state_t;

endpackage : idt_pkg

// ===== hdl/idt_down_counter.sv
// 32-bit down counter with load and reload at zero
`timescale 1ns/100ps
`default_nettype none
module idt_down_counter
  import idt_pkg::*;
#(
  parameter logic [31:0] RESET_COUNT = IDT_DEFAULT_PERIOD
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic run_in,
  input wire logic load_in,
  input wire logic [31:0] load_value_in,
  output logic [31:0] count_out,
  output logic hit_out
);

  idt_cnt_state_t st_reg;
  idt_cnt_state_t st_next;
  logic hit;

  always_comb begin
    st_next = st_reg;
    // load only happens while stopped, so hit needs no load term
    hit = run_in && (st_reg.count == IDT_COUNT_ZERO);
    if (load_in) begin
      st_next.count = load_value_in;
    end else if (run_in) begin
      // R07 reload at zero
      if (hit) begin
        st_next.count = load_value_in;
      end else begin
        // R01 one step per clock
        st_next.count = st_reg.count - IDT_COUNT_ONE;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      st_reg <= '{count: RESET_COUNT};
    end else begin
      st_reg <= st_next;
    end
  end

  assign count_out = st_reg.count;
  assign hit_out = hit;

endmodule : idt_down_counter
`default_nettype wire

// ===== hdl/idt_interval_timer.sv
// interval down timer: register port, flags, run control, snapshot
`timescale 1ns/100ps
`default_nettype none
module idt_interval_timer
  import idt_pkg::*;
#(
  parameter logic [31:0] DEFAULT_PERIOD = IDT_DEFAULT_PERIOD
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic bus_wr_in,
  input wire logic bus_rd_in,
  input wire logic [31:0] bus_addr_in,
  input wire logic [15:0] bus_wdata_in,
  output logic [15:0] bus_rdata_out,
  output logic bus_rvalid_out,
  output logic irq_out,
  output logic counting_out
);

  // one decoder shared by the write and read paths
  function automatic idt_sel_t idt_decode(input logic [31:0] addr);
    idt_sel_t sel;
    sel = IDT_SEL_NONE;
    // R02 six halfword registers
    unique case (addr)
      IDT_ADDR_STATUS: sel = IDT_SEL_STATUS;
      IDT_ADDR_CONTROL: sel = IDT_SEL_CONTROL;
      IDT_ADDR_PERIOD_LO: sel = IDT_SEL_PERIOD_LO;
      IDT_ADDR_PERIOD_HI: sel = IDT_SEL_PERIOD_HI;
      IDT_ADDR_SNAP_LO: sel = IDT_SEL_SNAP_LO;
      IDT_ADDR_SNAP_HI: sel = IDT_SEL_SNAP_HI;
      default: sel = IDT_SEL_NONE;
    endcase
    return sel;
  endfunction : idt_decode

  idt_state_t st_reg;
  idt_state_t st_next;
  idt_req_t req;
  idt_sel_t wsel;
  idt_sel_t rsel;
  logic cnt_load;
  logic [31:0] cnt_value;
  logic [31:0] cnt_count;
  logic cnt_hit;
  logic [15:0] rd_word;

  always_comb begin
    st_next = st_reg;
    req = '{wr: bus_wr_in, rd: bus_rd_in, addr: bus_addr_in,
            wdata: bus_wdata_in};
    wsel = req.wr ? idt_decode(req.addr) : IDT_SEL_NONE;
    rsel = req.rd ? idt_decode(req.addr) : IDT_SEL_NONE;
    cnt_load = 1'b0;
    rd_word = IDT_HALF_ZERO;

    // R03 sticky timeout on zero
    if (cnt_hit) begin
      st_next.timeout_flag = 1'b1;
      // R15 timeout makes request pending
      st_next.irq_pend = 1'b1;
      // R08 continuous keeps running
      // R09 one-shot stops at zero
      if (!st_reg.continuous_mode) begin
        st_next.counting_flag = 1'b0;
      end
    end

    unique case (wsel)
      IDT_SEL_STATUS: begin
        // R04 zero clears, event wins
        if (!req.wdata[IDT_STAT_TO_BIT] && !cnt_hit) begin
          st_next.timeout_flag = 1'b0;
        end
        // R16 any write drops request, event wins
        if (!cnt_hit) begin
          st_next.irq_pend = 1'b0;
        end
        // R06 counting_flag left as is
      end
      IDT_SEL_CONTROL: begin
        // R14 interrupt enable bit
        st_next.timeout_irq_enable = req.wdata[IDT_CTRL_ITO_BIT];
        st_next.continuous_mode = req.wdata[IDT_CTRL_CONTINUOUS_MODE_BIT];
        // R10 start and halt strobes
        // R21 halt wins, start resumes
        if (req.wdata[IDT_CTRL_HALT_BIT]) begin
          st_next.counting_flag = 1'b0;
        end else if (req.wdata[IDT_CTRL_START_BIT]) begin
          st_next.counting_flag = 1'b1;
        end
      end
      IDT_SEL_PERIOD_LO: begin
        // R11 period halves, preload if idle
        st_next.period_lo = req.wdata;
        cnt_load = !st_reg.counting_flag;
      end
      IDT_SEL_PERIOD_HI: begin
        // R18 high half completes the value
        st_next.period_hi = req.wdata;
        cnt_load = !st_reg.counting_flag;
      end
      IDT_SEL_SNAP_LO: begin
        // R13 capture live count
        st_next.snap_lo = cnt_count[15:0];
        st_next.snap_hi = cnt_count[31:16];
      end
      IDT_SEL_SNAP_HI: begin
        // read only, writes ignored
      end
      IDT_SEL_NONE: begin
      end
      default: begin
      end
    endcase

    // reload always uses the latest programmed value
    cnt_value = {st_next.period_hi, st_next.period_lo};

    unique case (rsel)
      IDT_SEL_STATUS: begin
        // R17 timeout at bit 0
        rd_word[IDT_STAT_TO_BIT] = st_reg.timeout_flag;
        // R05 running shown in status
        // R19 fixed positions
        rd_word[IDT_STAT_RUN_BIT] = st_reg.counting_flag;
      end
      IDT_SEL_CONTROL: begin
        // R19 start, halt read zero
        rd_word[IDT_CTRL_ITO_BIT] = st_reg.timeout_irq_enable;
        rd_word[IDT_CTRL_CONTINUOUS_MODE_BIT] = st_reg.continuous_mode;
      end
      IDT_SEL_PERIOD_LO: rd_word = st_reg.period_lo;
      IDT_SEL_PERIOD_HI: rd_word = st_reg.period_hi;
      IDT_SEL_SNAP_LO: rd_word = st_reg.snap_lo;
      IDT_SEL_SNAP_HI: rd_word = st_reg.snap_hi;
      IDT_SEL_NONE: rd_word = IDT_HALF_ZERO;
      default: rd_word = IDT_HALF_ZERO;
    endcase
    st_next.rdata = rd_word;
    st_next.rvalid = req.rd;
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      // R20 stopped, quiet, controls zero
      // R12 default start count
      st_reg <= '{timeout_flag: 1'b0,
                  counting_flag: 1'b0,
                  irq_pend: 1'b0,
                  timeout_irq_enable: 1'b0,
                  continuous_mode: 1'b0,
                  period_lo: DEFAULT_PERIOD[15:0],
                  period_hi: DEFAULT_PERIOD[31:16],
                  snap_lo: IDT_HALF_ZERO,
                  snap_hi: IDT_HALF_ZERO,
                  rdata: IDT_HALF_ZERO,
                  rvalid: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  // counter core only runs while counting_flag is set
  idt_down_counter #(
    .RESET_COUNT(DEFAULT_PERIOD)
  ) u_counter (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .run_in(st_reg.counting_flag),
    .load_in(cnt_load),
    .load_value_in(cnt_value),
    .count_out(cnt_count),
    .hit_out(cnt_hit)
  );

  assign bus_rdata_out = st_reg.rdata;
  assign bus_rvalid_out = st_reg.rvalid;
  // R15 gated interrupt request
  assign irq_out = st_reg.irq_pend & st_reg.timeout_irq_enable;
  assign counting_out = st_reg.counting_flag;

endmodule : idt_interval_timer
`default_nettype wire

// ===== bench/idt_timer_chk_sva.sv
// port assertions for the interval down timer
`timescale 1ns/100ps
`default_nettype none
module idt_timer_chk
  import idt_pkg::*;
#(
  parameter logic [31:0] DEFAULT_PERIOD = IDT_DEFAULT_PERIOD
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic bus_wr_in,
  input wire logic bus_rd_in,
  input wire logic [31:0] bus_addr_in,
  input wire logic [15:0] bus_wdata_in,
  input wire logic [15:0] bus_rdata_out,
  input wire logic bus_rvalid_out,
  input wire logic irq_out,
  input wire logic counting_out
);
  logic wr_ctl;
  logic wr_st;
  logic start_wr;
  logic ien_wr;
  logic rd_unmapped;
  assign rd_unmapped = bus_rd_in && !(bus_addr_in inside {IDT_ADDR_STATUS,
    IDT_ADDR_CONTROL, IDT_ADDR_PERIOD_LO, IDT_ADDR_PERIOD_HI,
    IDT_ADDR_SNAP_LO, IDT_ADDR_SNAP_HI});
  assign wr_ctl = bus_wr_in && (bus_addr_in == IDT_ADDR_CONTROL);
  assign wr_st = bus_wr_in && (bus_addr_in == IDT_ADDR_STATUS);
  assign start_wr = wr_ctl && bus_wdata_in[IDT_CTRL_START_BIT];
  assign ien_wr = wr_ctl && bus_wdata_in[IDT_CTRL_ITO_BIT];
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  rvalid_late_a: assert property (
    bus_rvalid_out == $past(bus_rd_in)) else $error("read answer late");
  start_runs_a: assert property (
    start_wr && !bus_wdata_in[IDT_CTRL_HALT_BIT] |=> counting_out)
    else $error("start did not run");
  halt_wins_a: assert property (
    wr_ctl && bus_wdata_in[IDT_CTRL_HALT_BIT] |=> !counting_out)
    else $error("halt did not stop");
  run_cause_a: assert property (
    $rose(counting_out) |-> $past(start_wr)) else $error("run w/o start");
  irq_cause_a: assert property (
    $rose(irq_out) |-> $past(counting_out) || $past(ien_wr))
    else $error("irq without timeout");
  irq_drop_a: assert property (
    wr_st && !counting_out |=> !irq_out) else $error("irq not dropped");
  unmapped_zero_a: assert property (
    rd_unmapped |=> bus_rdata_out == 16'h0000)
    else $error("unmapped read nonzero");
  status_read_a: assert property (
    bus_rd_in && bus_addr_in == IDT_ADDR_STATUS |=>
    bus_rdata_out[15:1] == {14'h0000, $past(counting_out)})
    else $error("status read wrong");
  cover property ($rose(irq_out));
  cover property ($fell(counting_out));
  cover property (start_wr ##1 counting_out);
endmodule : idt_timer_chk
bind idt_interval_timer idt_timer_chk #(.DEFAULT_PERIOD(DEFAULT_PERIOD))
  i_chk (.mclk_in(mclk_in), .rst_in(rst_in), .bus_wr_in(bus_wr_in),
  .bus_rd_in(bus_rd_in), .bus_addr_in(bus_addr_in),
  .bus_wdata_in(bus_wdata_in), .bus_rdata_out(bus_rdata_out),
  .bus_rvalid_out(bus_rvalid_out), .irq_out(irq_out),
  .counting_out(counting_out));
`default_nettype wire

// ===== bench/idt_interval_timer_tb.sv
// self-checking bench for the interval down timer
`timescale 1ns/100ps
`default_nettype none
module idt_interval_timer_tb;
  import idt_pkg::*;
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic [31:0] addr = 32'h0;
  logic [15:0] wd = 16'h0;
  logic [15:0] rdat;
  logic rv;
  logic irq;
  logic run;
  int n_mismatch = 0;
  int compares = 0;
  int c;
  always #4 mclk = ~mclk;
  // short reset period keeps the reset value cheap to check
  idt_interval_timer #(.DEFAULT_PERIOD(32'h0000_0014)) i_dut (
    .mclk_in(mclk), .rst_in(rst), .bus_wr_in(wr), .bus_rd_in(rd),
    .bus_addr_in(addr), .bus_wdata_in(wd), .bus_rdata_out(rdat),
    .bus_rvalid_out(rv), .irq_out(irq), .counting_out(run));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrr(input logic [31:0] a, input logic [15:0] d);
    @(posedge mclk);
    wr <= 1'h1;
    addr <= a;
    wd <= d;
    @(posedge mclk);
    wr <= 1'h0;
    #1;
  endtask : wrr
  task automatic rdc(input logic [31:0] a, input logic [15:0] e);
    @(posedge mclk);
    rd <= 1'h1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'h0;
    #1;
    chk({15'h0, rv}, 16'h1);
    chk(rdat, e);
  endtask : rdc
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'h0;
    begin : tests
    chk(IDT_DEFAULT_PERIOD[15:0], 16'h5E10);
    chk(IDT_DEFAULT_PERIOD[31:16], 16'h005F);
    rdc(IDT_ADDR_PERIOD_LO, 16'h0014);
    rdc(IDT_ADDR_PERIOD_HI, 16'h0000);
    rdc(IDT_ADDR_STATUS, 16'h0000);
    rdc(IDT_ADDR_CONTROL, 16'h0000);
    rdc(32'h1000_2018, 16'h0000);
    $display("reset test done");
    wrr(IDT_ADDR_PERIOD_HI, 16'h0001);
    wrr(IDT_ADDR_PERIOD_LO, 16'h0003);
    wrr(IDT_ADDR_SNAP_LO, 16'h0000);
    wrr(IDT_ADDR_SNAP_HI, 16'hFFFF);
    rdc(IDT_ADDR_SNAP_LO, 16'h0003);
    rdc(IDT_ADDR_SNAP_HI, 16'h0001);
    wrr(IDT_ADDR_PERIOD_HI, 16'h0000);
    wrr(IDT_ADDR_PERIOD_LO, 16'h0005);
    $display("period test done");
    wrr(IDT_ADDR_CONTROL, 16'h0007);
    repeat (20) @(posedge mclk);
    #1;
    chk({14'h0, run, irq}, 16'h3);
    rdc(IDT_ADDR_STATUS, 16'h0003);
    rdc(IDT_ADDR_CONTROL, 16'h0003);
    wrr(IDT_ADDR_STATUS, 16'h0000);
    chk({15'h0, run}, 16'h1);
    wrr(IDT_ADDR_CONTROL, 16'h000F);
    wrr(IDT_ADDR_STATUS, 16'h0002);
    chk({14'h0, run, irq}, 16'h0);
    rdc(IDT_ADDR_STATUS, 16'h0000);
    $display("continuous test done");
    wrr(IDT_ADDR_PERIOD_LO, 16'h0005);
    repeat (2) begin
      wrr(IDT_ADDR_CONTROL, 16'h0004);
      c = 0;
      while (run === 1'h1 && c < 100) begin
        @(posedge mclk);
        #1;
        c++;
      end
      if (c >= 100) begin
        n_mismatch++;
        disable tests;
      end
      chk(16'(c), 16'h0006);
    end
    rdc(IDT_ADDR_STATUS, 16'h0001);
    chk({15'h0, irq}, 16'h0);
    wrr(IDT_ADDR_CONTROL, 16'h0001);
    chk({15'h0, irq}, 16'h1);
    wrr(IDT_ADDR_STATUS, 16'h0001);
    chk({15'h0, irq}, 16'h0);
    rdc(IDT_ADDR_STATUS, 16'h0001);
    $display("one-shot test done");
    end : tests
    print_verdict();
  end
endmodule : idt_interval_timer_tb
`default_nettype wire
